// ---- hw/lrao_consts.svh ----
`ifndef LRAO_CONSTS_SVH
`define LRAO_CONSTS_SVH

// Register addresses on the byte-wide register port
`define LRAO_ADDR_LOOP_CTRL 8'h2C
`define LRAO_ADDR_PERIOD_HI 8'h2E
`define LRAO_ADDR_PERIOD_LO 8'h2F
`define LRAO_ADDR_IMP_COEF 8'h30

// Loop control field positions
`define LRAO_FALLBACK_EN_BIT 7
`define LRAO_ATTEMPT_MSB 6
`define LRAO_ATTEMPT_LSB 5
`define LRAO_WAVE_SHAPE_BIT 0

// Reset values
`define LRAO_PERIOD_RST 10'h0C6
`define LRAO_LOOP_CTRL_RST 8'h00
`define LRAO_IMP_COEF_RST 8'h00

// Fewest attempts, for attempt-count code 0
`define LRAO_ATTEMPT_BASE 3'h3

// Period step, in picoseconds, and clock period in picoseconds
`define LRAO_STEP_PS 24615000
`define LRAO_CLK_PS 10000
// Cycles per step, rounded to nearest
`define LRAO_STEP_CYCLES ((`LRAO_STEP_PS + (`LRAO_CLK_PS / 2)) / `LRAO_CLK_PS)

`endif

// ---- hw/lrao_pkg.sv ----
`default_nettype none

package lrao_pkg;

	// Drive engine states, Gray along idle -> closed -> open
	typedef enum logic [1:0] {
		LRAO_IDLE = 2'b00,
		LRAO_CLOSED = 2'b01,
		LRAO_OPEN = 2'b11
	} lrao_state_t;

endpackage

`default_nettype wire

// ---- hw/lrao_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lrao_consts.svh"

module lrao_top
	import lrao_pkg::*;
#(
	parameter int STEP_CYCLES = `LRAO_STEP_CYCLES,
	parameter int HALF_W = 24
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Diagnostic coefficient load
	input wire logic coef_load,
	input wire logic [7:0] coef_value,
	// Drive control and back-EMF
	input wire logic drive_run,
	input wire logic closed_loop_sel,
	input wire logic bemf_zc,
	// Drive outputs
	output logic drive_active,
	output logic drive_pol,
	output logic drive_sine_sel,
	output logic open_loop_active,
	output logic [HALF_W-1:0] resonance_half_cycles
);

	// Register state
	logic [9:0] open_loop_period_reg; // Programmed period in steps
	logic [7:0] loop_ctrl_reg; // Fallback enable, attempt count, wave shape
	logic [7:0] imp_coef_reg; // Impedance coefficient, read-only to host

	// Engine state
	lrao_state_t state_reg, state_next;
	logic [$clog2(STEP_CYCLES+1)-1:0] step_cnt_reg; // Prescaler within one step
	logic step_tick; // One step of 24.615 us elapsed
	logic [9:0] step_pos_reg; // Steps into current period
	logic [9:0] period_act_reg; // Period in use, latched at boundary
	logic [HALF_W-1:0] half_cnt_reg; // Cycles since last zero crossing
	logic [2:0] miss_cnt_reg; // Consecutive missed crossings
	logic miss_event; // A full period passed with no crossing
	logic [2:0] attempt_limit;

	// Register read mux, shared by read data path
	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		case (addr)
			`LRAO_ADDR_LOOP_CTRL: reg_read = loop_ctrl_reg;
			`LRAO_ADDR_PERIOD_HI: reg_read = {6'h00, open_loop_period_reg[9:8]};
			`LRAO_ADDR_PERIOD_LO: reg_read = open_loop_period_reg[7:0];
			`LRAO_ADDR_IMP_COEF: reg_read = imp_coef_reg;
			default: reg_read = 8'h00;
		endcase
	endfunction

	// Host writes to the period and control bytes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			open_loop_period_reg <= `LRAO_PERIOD_RST;
			loop_ctrl_reg <= `LRAO_LOOP_CTRL_RST;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				// Reserved high bits are dropped, read back zero
				`LRAO_ADDR_PERIOD_HI: open_loop_period_reg[9:8] <= reg_wdata[1:0];
				`LRAO_ADDR_PERIOD_LO: open_loop_period_reg[7:0] <= reg_wdata;
				// Reserved middle bits kept zero
				`LRAO_ADDR_LOOP_CTRL: loop_ctrl_reg <= reg_wdata & 8'hE1;
				default: begin
				end
			endcase
		end
	end

	// Coefficient comes only from the diagnostic side; host writes ignored
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			imp_coef_reg <= `LRAO_IMP_COEF_RST;
		end else if (ce && coef_load) begin
			imp_coef_reg <= coef_value;
		end
	end

	// Registered read data, held between reads
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_rd) begin
			reg_rdata <= reg_read(reg_addr);
		end
	end

	// Attempts before fallback: code plus three
	assign attempt_limit = `LRAO_ATTEMPT_BASE
		+ {1'b0, loop_ctrl_reg[`LRAO_ATTEMPT_MSB:`LRAO_ATTEMPT_LSB]};

	// Step prescaler, restarted whenever the engine is idle
	assign step_tick = (step_cnt_reg == ($bits(step_cnt_reg))'(STEP_CYCLES - 1));
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			step_cnt_reg <= '0;
		end else if (ce) begin
			if (state_reg == LRAO_IDLE || step_tick) begin
				step_cnt_reg <= '0;
			end else begin
				step_cnt_reg <= step_cnt_reg + 1'b1;
			end
		end
	end

	// Missed crossing: a whole period of steps without back-EMF crossing
	assign miss_event = (state_reg == LRAO_CLOSED) && step_tick && !bemf_zc
		&& (step_pos_reg + 10'h001 >= period_act_reg);

	// Engine next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LRAO_IDLE: begin
				if (drive_run) begin
					state_next = closed_loop_sel ? LRAO_CLOSED : LRAO_OPEN;
				end
			end
			LRAO_CLOSED: begin
				if (!drive_run) begin
					state_next = LRAO_IDLE;
				end else if (miss_event && loop_ctrl_reg[`LRAO_FALLBACK_EN_BIT]
					&& (miss_cnt_reg + 3'h1 >= attempt_limit)) begin
					state_next = LRAO_OPEN;
				end
			end
			LRAO_OPEN: begin
				if (!drive_run) begin
					state_next = LRAO_IDLE;
				end
			end
			default: state_next = LRAO_IDLE;
		endcase
	end

	// Engine state register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= LRAO_IDLE;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// Miss counter; any crossing clears it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			miss_cnt_reg <= 3'h0;
		end else if (ce) begin
			if (state_reg != LRAO_CLOSED || bemf_zc) begin
				miss_cnt_reg <= 3'h0;
			end else if (miss_event && miss_cnt_reg != 3'h7) begin
				miss_cnt_reg <= miss_cnt_reg + 3'h1;
			end
		end
	end

	// Step position within the period; new period only at the boundary
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			step_pos_reg <= 10'h000;
			period_act_reg <= `LRAO_PERIOD_RST;
		end else if (ce) begin
			if (state_reg == LRAO_IDLE || (state_reg == LRAO_CLOSED && bemf_zc)) begin
				step_pos_reg <= 10'h000;
				period_act_reg <= open_loop_period_reg;
			end else if (step_tick) begin
				if (step_pos_reg + 10'h001 >= period_act_reg) begin
					step_pos_reg <= 10'h000;
					period_act_reg <= open_loop_period_reg;
				end else begin
					step_pos_reg <= step_pos_reg + 10'h001;
				end
			end
		end
	end

	// Half-cycle measurement between back-EMF crossings
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			half_cnt_reg <= '0;
			resonance_half_cycles <= '0;
		end else if (ce) begin
			if (state_reg != LRAO_CLOSED) begin
				half_cnt_reg <= '0;
			end else if (bemf_zc) begin
				// Each crossing gives a fresh estimate, no averaging
				// Saturated count is published as is, never wraps to zero
				resonance_half_cycles <= (half_cnt_reg == '1) ? half_cnt_reg
					: half_cnt_reg + 1'b1;
				half_cnt_reg <= '0;
			end else if (half_cnt_reg != '1) begin
				half_cnt_reg <= half_cnt_reg + 1'b1;
			end
		end
	end

	// Drive polarity: crossings in closed loop, half periods in open loop
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			drive_pol <= 1'b0;
		end else if (ce) begin
			case (state_reg)
				LRAO_CLOSED: begin
					// Flip on every crossing, and on each missed period with no crossing
					if (bemf_zc || miss_event) begin
						drive_pol <= ~drive_pol;
					end
				end
				LRAO_OPEN: begin
					if (step_tick && (step_pos_reg + 10'h001 == {1'b0, period_act_reg[9:1]}
						|| step_pos_reg + 10'h001 >= period_act_reg)) begin
						drive_pol <= ~drive_pol;
					end
				end
				default: drive_pol <= 1'b0;
			endcase
		end
	end

	// Status and shape outputs; fallback entry always drives square
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			drive_active <= 1'b0;
			open_loop_active <= 1'b0;
			drive_sine_sel <= 1'b0;
		end else if (ce) begin
			drive_active <= (state_next != LRAO_IDLE);
			open_loop_active <= (state_next == LRAO_OPEN);
			if (state_next == LRAO_IDLE) begin
				// Shape select only stands while open loop runs
				drive_sine_sel <= 1'b0;
			end else if (state_reg == LRAO_IDLE) begin
				drive_sine_sel <= !closed_loop_sel
					&& loop_ctrl_reg[`LRAO_WAVE_SHAPE_BIT];
			end else if (state_reg == LRAO_CLOSED && state_next == LRAO_OPEN) begin
				drive_sine_sel <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ---- tb/lrao_actuator_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module lrao_actuator_model (
	// Clock and swing control
	input wire logic sys_clk,
	input wire logic zc_en,
	input wire logic [7:0] gap,
	// Back-EMF crossing pulse
	output logic bemf_zc
);
	logic [7:0] cnt_reg; // Cycles since last crossing
	initial bemf_zc = 1'h0;
	// One crossing every gap cycles while the mass swings
	always @(posedge sys_clk) begin
		cnt_reg <= (!zc_en || bemf_zc) ? 8'h01 : cnt_reg + 8'h01;
		bemf_zc <= zc_en && cnt_reg == gap - 8'h01;
	end
endmodule
`default_nettype wire

// ---- tb/lrao_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module lrao_monitor #(
	parameter int STEP_CYCLES = 4,
	parameter int HALF_W = 24
) (
	// Clock, reset, enable, register read
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Drive side
	input wire logic drive_run,
	input wire logic bemf_zc,
	input wire logic drive_active,
	input wire logic drive_pol,
	input wire logic drive_sine_sel,
	input wire logic open_loop_active,
	input wire logic [HALF_W-1:0] resonance_half_cycles
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// Crossing seen while tracking in closed loop
	logic zc_take;
	assign zc_take = ce && drive_run && drive_active && !open_loop_active && bemf_zc;
	a_reset_clears: assert property (disable iff (1'b0) srst && ce |=>
		reg_rdata == 8'h00 && !drive_active) else $error("reset left state");
	a_start_active: assert property (ce && drive_run && !drive_active |=>
		drive_active) else $error("engine did not start");
	a_stop_idle: assert property (ce && !drive_run && drive_active |=>
		!drive_active) else $error("engine did not stop");
	a_zc_flips_pol: assert property (zc_take |=> drive_pol != $past(drive_pol))
		else $error("crossing did not flip polarity");
	a_zc_publishes: assert property (zc_take |=> resonance_half_cycles != '0)
		else $error("crossing left no half cycle count");
	a_sine_open: assert property (drive_sine_sel |-> open_loop_active)
		else $error("sine outside open loop");
	a_idle_quiet: assert property (!drive_active |-> !open_loop_active)
		else $error("open loop flag while idle");
	a_rdata_holds: assert property (ce && !reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_open_pol_spaced: assert property ($changed(drive_pol) && open_loop_active |=>
		($stable(drive_pol) || !open_loop_active)[*3]) else $error("open loop half too short");
	// Main scenarios reached
	c_zc: cover property (zc_take);
	c_sine: cover property (open_loop_active && drive_sine_sel);
	c_fallback: cover property ($rose(open_loop_active) && !drive_sine_sel);
endmodule
bind lrao_top lrao_monitor #(.STEP_CYCLES(STEP_CYCLES), .HALF_W(HALF_W)) u_lrao_monitor (
	.sys_clk(sys_clk), .srst(srst), .ce(ce), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.drive_run(drive_run), .bemf_zc(bemf_zc), .drive_active(drive_active),
	.drive_pol(drive_pol), .drive_sine_sel(drive_sine_sel),
	.open_loop_active(open_loop_active), .resonance_half_cycles(resonance_half_cycles));
`default_nettype wire

// ---- tb/lrao_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module lrao_top_tb;
	// Stimulus, all but the free-running clock driven from the clock edge
	logic sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, coef_load = 1'h0;
	logic drive_run = 1'h0, closed_loop_sel = 1'h0, zc_en = 1'h0, ce = 1'h1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, coef_value = 8'h00, gap = 8'h0A;
	// Observed outputs
	logic [7:0] reg_rdata;
	logic drive_active, drive_pol, drive_sine_sel, open_loop_active, bemf_zc;
	logic [23:0] res_hc, v1;
	int miscompares = 0, checked = 0, n;
	// Short step keeps the run small; period 8 gives 32-cycle periods
	lrao_top #(.STEP_CYCLES(4), .HALF_W(24)) u_lrao_top (.sys_clk(sys_clk), .srst(srst),
		.ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .coef_load(coef_load),
		.coef_value(coef_value), .drive_run(drive_run), .closed_loop_sel(closed_loop_sel),
		.bemf_zc(bemf_zc), .drive_active(drive_active), .drive_pol(drive_pol),
		.drive_sine_sel(drive_sine_sel), .open_loop_active(open_loop_active),
		.resonance_half_cycles(res_hc));
	lrao_actuator_model u_lrao_actuator_model (.sys_clk(sys_clk), .zc_en(zc_en),
		.gap(gap), .bemf_zc(bemf_zc));
	initial forever #5 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [23:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		if (miscompares == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Register write, one-cycle strobe, then an idle edge before the next request
	task automatic wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		@(posedge sys_clk);
	endtask
	// Register read; data settled one edge after the strobe edge
	task automatic rd(input logic [7:0] a, exp);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(posedge sys_clk);
		chk("reg_rdata", {16'h0000, reg_rdata}, {16'h0000, exp});
	endtask
	// Edges until polarity moves; a hang counts as a miss
	task automatic wait_flip(output int k);
		logic p;
		p = drive_pol;
		k = 0;
		while (drive_pol === p && k < 900) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 900) begin
			miscompares++;
			test_done();
		end
	endtask
	task automatic t_regs;
		rd(8'h2E, 8'h00);
		rd(8'h2F, 8'hC6);
		rd(8'h30, 8'h00);
		wr(8'h2E, 8'hFF);
		rd(8'h2E, 8'h03);
		coef_value <= 8'h5A;
		coef_load <= 1'h1;
		@(posedge sys_clk);
		coef_load <= 1'h0;
		wr(8'h30, 8'h11);
		rd(8'h30, 8'h5A);
		rd(8'h55, 8'h00);
		wr(8'h2C, 8'hFF);
		rd(8'h2C, 8'hE1);
	endtask
	// Open loop with sine: half period is 4 steps of 4 cycles
	task automatic t_open;
		logic pol_held;
		wr(8'h2E, 8'h00);
		wr(8'h2F, 8'h08);
		wr(8'h2C, 8'h01);
		rd(8'h2F, 8'h08);
		closed_loop_sel <= 1'h0;
		drive_run <= 1'h1;
		repeat (2) @(posedge sys_clk);
		chk("sine_sel", {23'h000000, drive_sine_sel}, 24'h000001);
		chk("drive_active", {23'h000000, drive_active}, 24'h000001);
		wait_flip(n);
		wait_flip(n);
		chk("half_period", n[23:0], 24'h000010);
		// Enable low: polarity frozen across a due flip, write ignored
		pol_held = drive_pol;
		ce <= 1'h0;
		wr(8'h2F, 8'h20);
		repeat (20) @(posedge sys_clk);
		chk("frozen_pol", {23'h000000, drive_pol}, {23'h000000, pol_held});
		ce <= 1'h1;
		rd(8'h2F, 8'h08);
		drive_run <= 1'h0;
		repeat (2) @(posedge sys_clk);
	endtask
	// Closed loop: slower swing lengthens the half cycle count
	task automatic t_closed;
		wr(8'h2C, 8'h00);
		closed_loop_sel <= 1'h1;
		zc_en <= 1'h1;
		drive_run <= 1'h1;
		repeat (45) @(posedge sys_clk);
		v1 = res_hc;
		gap <= 8'h0E;
		repeat (60) @(posedge sys_clk);
		chk("half_cycle_delta", res_hc - v1, 24'h000004);
		chk("open_loop", {23'h000000, open_loop_active}, 24'h000000);
		drive_run <= 1'h0;
		zc_en <= 1'h0;
		repeat (2) @(posedge sys_clk);
	endtask
	// Silent actuator: fallback after 3+code missed periods, always square
	task automatic t_fallback;
		// Fallback disabled: misses never leave closed loop
		wr(8'h2C, 8'h60);
		drive_run <= 1'h1;
		repeat (7 * 32) @(posedge sys_clk);
		chk("no_fallback", {23'h000000, open_loop_active}, 24'h000000);
		chk("still_active", {23'h000000, drive_active}, 24'h000001);
		drive_run <= 1'h0;
		repeat (2) @(posedge sys_clk);
		for (int c = 0; c < 4; c++) begin
			wr(8'h2C, 8'h81 | (c[7:0] << 5));
			drive_run <= 1'h1;
			repeat ((3 + c) * 32 + 1) @(posedge sys_clk);
			chk("early_fallback", {23'h000000, open_loop_active}, 24'h000000);
			@(posedge sys_clk);
			chk("fallback", {23'h000000, open_loop_active}, 24'h000001);
			chk("fallback_sine", {23'h000000, drive_sine_sel}, 24'h000000);
			drive_run <= 1'h0;
			repeat (2) @(posedge sys_clk);
		end
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'h0;
		@(posedge sys_clk);
		t_regs();
		t_open();
		t_closed();
		t_fallback();
		test_done();
	end
endmodule
`default_nettype wire
